// ---- bench/odcd_sink.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Clock consumer model
// ****************************************************************
module odcd_sink (
   // Clock and watched clock output
   input  wire        clk_i,
   input  wire        sig_i,
   // Last complete high and low run, in fast clock cycles
   output logic [7:0] hi_len_o,
   output logic [7:0] lo_len_o
);
   logic [7:0] run;
   logic       last;
   // Runs saturate so a stopped clock cannot wrap into a plausible length
   always @(posedge clk_i) begin
      if (sig_i !== last) begin
         if (last === 1'b1)
            hi_len_o <= run;
         if (last === 1'b0)
            lo_len_o <= run;
         run <= 8'h01;
      end else if (run != 8'hFF) begin
         run <= run + 8'h01;
      end
      last <= sig_i;
   end
endmodule

// ---- bench/odcd_top_props.sv ----
`timescale 1ns/1ns
// ****************************************************************
// Port checks of the divider block
// ****************************************************************
module odcd_top_props #(
   parameter NUM_OUT = 8,
   parameter CNT_W   = 4
) (
   // Watched ports
   input wire               clk_sys_i,
   input wire               rstn_i,
   input wire               sci_cs_n_i,
   input wire               sci_sclk_i,
   input wire               sci_sdi_i,
   input wire               sci_sdo_o,
   input wire               sci_sdo_oe_o,
   input wire               align_hold_n_i,
   input wire [NUM_OUT-1:0] clock_outputs_o,
   input wire [NUM_OUT-1:0] bypass_sel_o
);
   logic [5:0] free_cnt;
   logic [5:0] run_cnt;
   logic       last_out;
   // The bench leaves the top output exempt from alignment, so it runs on
   wire  [NUM_OUT-2:0] aligned_out = clock_outputs_o[NUM_OUT-2:0];
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);
   // Free time of output 0 and its run length; a held run needs time to end
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         free_cnt <= 6'h00;
         run_cnt  <= 6'h00;
         last_out <= 1'b0;
      end else begin
         free_cnt <= (!align_hold_n_i || bypass_sel_o[0]) ? 6'h00 :
                     (free_cnt == 6'h3F) ? free_cnt : free_cnt + 6'h01;
         run_cnt  <= (clock_outputs_o[0] != last_out) ? 6'h01 :
                     (run_cnt == 6'h3F) ? run_cnt : run_cnt + 6'h01;
         last_out <= clock_outputs_o[0];
      end
   end
   AST_PHASE_MAX: assert property (free_cnt == 6'h3F |-> run_cnt <= 6'h10)
      else $error("clock phase longer than sixteen cycles");
   AST_BYPASS_LOW: assert property ((bypass_sel_o & clock_outputs_o) == '0)
      else $error("bypassed divider output not low");
   AST_OE_NEEDS_CS: assert property ($rose(sci_sdo_oe_o) |-> !sci_cs_n_i)
      else $error("read data driven without chip select");
   AST_OE_DROPS: assert property (sci_cs_n_i [*6] |-> !sci_sdo_oe_o)
      else $error("read data still driven after deselect");
   AST_SDO_STEADY: assert property (sci_sclk_i [*5] |-> $stable(sci_sdo_o))
      else $error("read data moved while serial clock high");
   AST_HOLD_FREEZE: assert property (!align_hold_n_i [*6] |-> $stable(aligned_out))
      else $error("clock output moved during alignment hold");
   AST_HOLD_RELEASE: assert property ($rose(align_hold_n_i) |->
      ##1 $stable(aligned_out) [*2])
      else $error("clock output moved too soon after hold release");
   AST_RESET_OUT: assert property ($rose(rstn_i) |->
      clock_outputs_o == '0 && !sci_sdo_oe_o)
      else $error("outputs not quiet after reset");
   // Main scenarios
   COV_LONG_PHASE: cover property (free_cnt == 6'h3F && run_cnt == 6'h10);
   COV_READ: cover property ($rose(sci_sdo_oe_o));
   COV_BYPASS: cover property (bypass_sel_o != '0);
endmodule
bind odcd_top odcd_top_props #(.NUM_OUT(NUM_OUT), .CNT_W(CNT_W)) odcd_top_props_inst (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sci_cs_n_i(sci_cs_n_i),
   .sci_sclk_i(sci_sclk_i), .sci_sdi_i(sci_sdi_i), .sci_sdo_o(sci_sdo_o),
   .sci_sdo_oe_o(sci_sdo_oe_o), .align_hold_n_i(align_hold_n_i),
   .clock_outputs_o(clock_outputs_o), .bypass_sel_o(bypass_sel_o));

// ---- bench/tb_output_clock_divider_duty.sv ----
`timescale 1ns/1ns
`include "odcd_consts.vh"
`define CHK(nm, e, g) begin \
   compares++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("mismatch %s exp %0h seen %0h", nm, e, g); \
   end \
end
// ****************************************************************
// Divider block bench
// ****************************************************************
module tb_output_clock_divider_duty;
   logic       clk_sys_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic       sci_cs_n_i = 1'b1;
   logic       sci_sclk_i = 1'b0;
   logic       sci_sdi_i = 1'b0;
   logic       align_hold_n_i = 1'b1;
   wire        sci_sdo_o;
   wire        sci_sdo_oe_o;
   wire  [7:0] clock_outputs_o;
   wire  [7:0] bypass_sel_o;
   logic [7:0] hi_len [8];
   logic [7:0] lo_len [8];
   logic [7:0] tbl [8] = '{8'hFF, 8'h00, 8'h42, 8'h24, 8'h33, 8'hF0, 8'h0F, 8'hA1};
   int         compares = 0;
   int         n_mismatch = 0;
   int         cyc = 0;
   odcd_top odcd_top_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sci_cs_n_i(sci_cs_n_i),
      .sci_sclk_i(sci_sclk_i), .sci_sdi_i(sci_sdi_i), .sci_sdo_o(sci_sdo_o),
      .sci_sdo_oe_o(sci_sdo_oe_o), .align_hold_n_i(align_hold_n_i),
      .clock_outputs_o(clock_outputs_o), .bypass_sel_o(bypass_sel_o));
   for (genvar gi = 0; gi < 8; gi++) begin : g_sink
      odcd_sink odcd_sink_inst (.clk_i(clk_sys_i), .sig_i(clock_outputs_o[gi]),
         .hi_len_o(hi_len[gi]), .lo_len_o(lo_len[gi]));
   end
   // 250 MHz fast clock
   always #2 clk_sys_i = ~clk_sys_i;
   // A hang is cut short well past the longest expected run
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out;
      end
   end
   task close_out;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Serial frame; sclk halves of six cycles keep the synchroniser margins
   task automatic frame(input logic [15:0] ins, input logic [15:0] wd, input int nb,
                        output logic [7:0] rd);
      logic [39:0] sh;
      sh = {ins, wd, 8'h00};
      rd = 8'h00;
      sci_cs_n_i = 1'b0;
      for (int i = 0; i < 16 + 8 * nb; i++) begin
         sci_sclk_i = 1'b0;
         sci_sdi_i = sh[39-i];
         repeat (6) @(negedge clk_sys_i);
         rd = {rd[6:0], sci_sdo_o};
         sci_sclk_i = 1'b1;
         repeat (6) @(negedge clk_sys_i);
      end
      sci_sclk_i = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      sci_cs_n_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] rd;
      frame({3'b000, a}, {d, 8'h00}, 1, rd);
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
      logic [7:0] rd;
      frame({3'b100, a}, 16'h0000, 1, rd);
      `CHK("reg_read", e, rd)
   endtask
   task automatic t_defaults;
      rd_chk(`ODCD_SET_FIRST, 8'h00);
      rd_chk(`ODCD_SET_LAST, 8'h00);
      rd_chk(13'h0058, 8'h00);
      `CHK("default_hi", 8'h01, hi_len[7])
      `CHK("default_lo", 8'h01, lo_len[7])
   endtask
   // Boundary and split settings on all eight outputs, then read back
   task automatic t_table;
      for (int i = 0; i < 8; i++)
         wr(`ODCD_SET_FIRST + 13'(2 * i), tbl[i]);
      repeat (100) @(negedge clk_sys_i);
      for (int i = 0; i < 8; i++) begin
         `CHK("hi_len", {4'h0, tbl[i][3:0]} + 8'h01, hi_len[i])
         `CHK("lo_len", {4'h0, tbl[i][7:4]} + 8'h01, lo_len[i])
         rd_chk(`ODCD_SET_FIRST + 13'(2 * i), tbl[i]);
      end
   endtask
   // Rewriting a running output must show only whole old or new phases
   task automatic watch_runs;
      int run;
      int n;
      logic lv;
      run = 0;
      n = 0;
      lv = clock_outputs_o[0];
      repeat (420) begin
         @(negedge clk_sys_i);
         if (clock_outputs_o[0] !== lv) begin
            if (n > 0)
               `CHK("run_len", 1'b1, (run == 1 || run == 16))
            n++;
            run = 0;
            lv = clock_outputs_o[0];
         end
         run++;
      end
   endtask
   task automatic t_rewrite;
      fork
         wr(`ODCD_SET_FIRST, 8'h00);
         watch_runs;
      join
      `CHK("new_hi", 8'h01, hi_len[0])
   endtask
   // Streamed pair: out2 setting then out1 control with bypass set
   task automatic t_bypass;
      logic [7:0] rd;
      frame({3'b000, 13'h004C}, 16'h2101, 2, rd);
      wr(13'h004A, 8'h52);
      repeat (100) @(negedge clk_sys_i);
      `CHK("bypass_sel", 1'b1, bypass_sel_o[1])
      `CHK("bypass_out", 1'b0, clock_outputs_o[1])
      `CHK("stream_hi", 8'h02, hi_len[2])
      `CHK("stream_lo", 8'h03, lo_len[2])
      wr(13'h004B, 8'h00);
      repeat (100) @(negedge clk_sys_i);
      `CHK("bypass_off", 1'b0, bypass_sel_o[1])
      `CHK("resume_hi", 8'h03, hi_len[1])
      `CHK("resume_lo", 8'h06, lo_len[1])
   endtask
   // out4 lags out3 by its phase offset; out5 holds high meanwhile;
   // out7 is exempt from alignment and keeps running through the hold
   task automatic t_hold;
      int t3;
      int t4;
      int tg;
      logic lv;
      t3 = -1;
      t4 = -1;
      tg = 0;
      wr(13'h004E, 8'h11);
      wr(13'h0050, 8'h11);
      wr(13'h0051, 8'h20);
      wr(13'h0053, 8'h02);
      wr(13'h0057, 8'h04);
      lv = clock_outputs_o[7];
      align_hold_n_i = 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_sys_i);
         if (clock_outputs_o[7] !== lv)
            tg++;
         lv = clock_outputs_o[7];
      end
      `CHK("hold_low", 1'b0, clock_outputs_o[3])
      `CHK("hold_high", 1'b1, clock_outputs_o[5])
      `CHK("hold_exempt", 1'b1, (tg >= 2))
      align_hold_n_i = 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk_sys_i);
         if (t3 < 0 && clock_outputs_o[3] === 1'b1)
            t3 = i;
         if (t4 < 0 && clock_outputs_o[4] === 1'b1)
            t4 = i;
      end
      `CHK("phase_lag", 2, t4 - t3)
   endtask
   initial begin
      repeat (20) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      t_defaults;
      t_table;
      t_rewrite;
      t_bypass;
      t_hold;
      close_out;
   end
endmodule

// ---- inc/odcd_consts.vh ----
// Function
// - Eight divider-setting registers, one per clock output, sit at even addresses 0x48 to 0x56.
// - Bits 3..0 of a divider-setting register are the on-count (high cycles minus one).
// - Bits 7..4 of a divider-setting register are the off-count (low cycles minus one).
// - Both counts are four bits wide and every value 0 to 15 is legal.
// - The output period is (on-count + 1) + (off-count + 1) fast clock cycles.
// - The output is high for on-count + 1 cycles of each period, which sets the duty cycle.
// - A bypass setting raises bypass_sel_o so the output mux passes the fast clock, and holds the divider idle with its output low.
// - While align_hold_n is low an affected divider holds its start level, then starts after
//     its phase offset once align_hold_n rises.
`ifndef ODCD_CONSTS_VH
`define ODCD_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ODCD_ADDR_W        13
`define ODCD_SET_FIRST     13'h0048
`define ODCD_SET_LAST      13'h0056
`define ODCD_CTL_FIRST     13'h0049
`define ODCD_CTL_LAST      13'h0057
`define ODCD_SET_RESET     8'h00
`define ODCD_CTL_RESET     8'h00
`define ODCD_UNMAPPED_RD   8'h00
`define ODCD_PIN_IDLE      4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define ODCD_ON_LSB        0
`define ODCD_ON_MSB        3
`define ODCD_OFF_LSB       4
`define ODCD_OFF_MSB       7
`define ODCD_CTL_BYPASS    0
`define ODCD_CTL_START_HI  1
`define ODCD_CTL_NO_ALIGN  2
`define ODCD_PHASE_LSB     4
`define ODCD_PHASE_MSB     7

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define ODCD_INSTR_BITS    5'h10
`define ODCD_INSTR_LAST    5'h0F
`define ODCD_BYTE_LAST     5'h07
`define ODCD_RW_BIT        15
`define ODCD_ADDR_STEP     13'h0001

`endif

// ---- verilog/odcd_divider.v ----
`timescale 1ns/1ns
`include "odcd_consts.vh"

module odcd_divider #(
   parameter CNT_W = 4
) (
   // Clock and reset
   input  wire             clk_i,
   input  wire             rstn_i,
   // Settings
   input  wire [CNT_W-1:0] on_cnt_i,
   input  wire [CNT_W-1:0] off_cnt_i,
   input  wire [CNT_W-1:0] phase_i,
   input  wire             bypass_i,
   input  wire             start_high_i,
   input  wire             no_align_i,
   // Alignment hold, already synchronised
   input  wire             hold_i,
   // Divided clock
   output reg              div_o
);

   reg [CNT_W-1:0] cnt;
   reg [CNT_W-1:0] on_q;
   reg [CNT_W-1:0] off_q;
   reg [CNT_W-1:0] wait_cnt;
   reg             waiting;

   // ****************************************************************
   // Counter: high phase, low phase, alignment hold
   // ****************************************************************
   // Counts are reloaded at the end of the low phase, and while bypassed or held,
   // so a rewrite never cuts a running phase short.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_o    <= 1'b0;
         cnt      <= {CNT_W{1'b0}};
         on_q     <= {CNT_W{1'b0}};
         off_q    <= {CNT_W{1'b0}};
         wait_cnt <= {CNT_W{1'b0}};
         waiting  <= 1'b0;
      end else if (bypass_i) begin
         // Divider idle while bypassed; output mux takes the fast clock
         div_o    <= 1'b0;
         cnt      <= {CNT_W{1'b0}};
         on_q     <= on_cnt_i;
         off_q    <= off_cnt_i;
         waiting  <= 1'b0;
      end else if (hold_i && !no_align_i) begin
         div_o    <= start_high_i;
         cnt      <= {CNT_W{1'b0}};
         on_q     <= on_cnt_i;
         off_q    <= off_cnt_i;
         wait_cnt <= phase_i;
         waiting  <= 1'b1;
      end else if (waiting) begin
         // Hold the start level for the phase offset, then run
         if (wait_cnt == {CNT_W{1'b0}}) begin
            waiting <= 1'b0;
         end else begin
            wait_cnt <= wait_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end else if (div_o) begin
         if (cnt == on_q) begin
            div_o <= 1'b0;
            cnt   <= {CNT_W{1'b0}};
         end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end else begin
         if (cnt == off_q) begin
            div_o <= 1'b1;
            cnt   <= {CNT_W{1'b0}};
            on_q  <= on_cnt_i;
            off_q <= off_cnt_i;
         end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ---- verilog/odcd_top.v ----
`timescale 1ns/1ns
`include "odcd_consts.vh"

module odcd_top #(
   parameter NUM_OUT = 8,
   parameter CNT_W   = 4
) (
   // Fast clock and reset
   input  wire               clk_sys_i,
   input  wire               rstn_i,
   // Serial control interface
   input  wire               sci_cs_n_i,
   input  wire               sci_sclk_i,
   input  wire               sci_sdi_i,
   output reg                sci_sdo_o,
   output reg                sci_sdo_oe_o,
   // Alignment hold pin, active low
   input  wire               align_hold_n_i,
   // Clock outputs
   output wire [NUM_OUT-1:0] clock_outputs_o,
   output reg  [NUM_OUT-1:0] bypass_sel_o
);

   // ****************************************************************
   // Serial state machine encoding
   // ****************************************************************
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_INSTR = 3'h2;
   localparam [2:0] ST_DATA  = 3'h4;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg                    rst_meta;
   reg                    rst_n;
   reg  [3:0]             pin_meta;
   reg  [3:0]             pin_sync;
   reg                    sclk_d;
   reg  [2:0]             state;
   reg  [4:0]             bit_cnt;
   reg  [15:0]            instr_sh;
   reg  [7:0]             wr_sh;
   reg  [7:0]             rd_sh;
   reg                    rd_mode;
   reg  [`ODCD_ADDR_W-1:0] addr;
   reg                    wr_stb;
   reg  [`ODCD_ADDR_W-1:0] wr_addr;
   reg  [7:0]             wr_data;
   reg  [7:0]             div_set [0:NUM_OUT-1];
   reg  [7:0]             div_ctl [0:NUM_OUT-1];
   reg  [7:0]             rd_data;
   reg  [`ODCD_ADDR_W-1:0] rd_addr;
   integer                i;
   integer                j;

   wire cs_n_s  = pin_sync[0];
   wire sclk_s  = pin_sync[1];
   wire sdi_s   = pin_sync[2];
   wire hold_s  = ~pin_sync[3];
   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   wire [`ODCD_ADDR_W-1:0] instr_addr = {instr_sh[11:0], sdi_s};
   wire [`ODCD_ADDR_W-1:0] next_addr  = addr - `ODCD_ADDR_STEP;

   // ****************************************************************
   // Address decode helpers
   // ****************************************************************
   // Hit on a divider-setting register: even address in the window
   function set_hit;
      input [`ODCD_ADDR_W-1:0] a;
      begin
         set_hit = (a >= `ODCD_SET_FIRST) && (a <= `ODCD_SET_LAST) && !a[0];
      end
   endfunction

   // Hit on a divider control register: odd address in the window
   function ctl_hit;
      input [`ODCD_ADDR_W-1:0] a;
      begin
         ctl_hit = (a >= `ODCD_CTL_FIRST) && (a <= `ODCD_CTL_LAST) && a[0];
      end
   endfunction

   // Output index; odd and even neighbours share one index
   function [2:0] out_idx;
      input [`ODCD_ADDR_W-1:0] a;
      reg   [`ODCD_ADDR_W-1:0] d;
      begin
         d       = a - `ODCD_SET_FIRST;
         out_idx = d[3:1];
      end
   endfunction

   // ****************************************************************
   // Reset release
   // ****************************************************************
   // Asserts at once, releases two edges later, so no flop leaves
   // reset on a marginal edge.
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Order: cs_n, sclk, sdi, align_hold_n. Idle levels at reset.
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= `ODCD_PIN_IDLE;
         pin_sync <= `ODCD_PIN_IDLE;
         sclk_d   <= 1'b0;
      end else begin
         pin_meta <= {align_hold_n_i, sci_sdi_i, sci_sclk_i, sci_cs_n_i};
         pin_sync <= pin_meta;
         sclk_d   <= sclk_s;
      end
   end

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   // During the instruction the address still sits in the shifter;
   // later bytes of a stream read the next lower address.
   always @* begin
      rd_addr = (state == ST_DATA) ? next_addr : instr_addr;
      if (set_hit(rd_addr)) begin
         rd_data = div_set[out_idx(rd_addr)];
      end else if (ctl_hit(rd_addr)) begin
         rd_data = div_ctl[out_idx(rd_addr)];
      end else begin
         rd_data = `ODCD_UNMAPPED_RD;
      end
   end

   // ****************************************************************
   // Serial control interface
   // ****************************************************************
   // SCLK is sampled by the fast clock, so each SCLK level must last
   // at least three fast clock cycles; this avoids a second domain.
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state        <= ST_IDLE;
         bit_cnt      <= 5'h00;
         instr_sh     <= 16'h0000;
         wr_sh        <= 8'h00;
         rd_sh        <= 8'h00;
         rd_mode      <= 1'b0;
         addr         <= {`ODCD_ADDR_W{1'b0}};
         wr_stb       <= 1'b0;
         wr_addr      <= {`ODCD_ADDR_W{1'b0}};
         wr_data      <= 8'h00;
         sci_sdo_o    <= 1'b0;
         sci_sdo_oe_o <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (cs_n_s) begin
            // Deselect aborts any partial byte
            state        <= ST_IDLE;
            bit_cnt      <= 5'h00;
            sci_sdo_oe_o <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  state   <= ST_INSTR;
                  bit_cnt <= 5'h00;
               end
               ST_INSTR: begin
                  if (sclk_rise) begin
                     instr_sh <= {instr_sh[14:0], sdi_s};
                     bit_cnt  <= bit_cnt + 5'h01;
                     if (bit_cnt == `ODCD_INSTR_LAST) begin
                        rd_mode <= instr_sh[`ODCD_RW_BIT-1];
                        addr    <= instr_addr;
                        rd_sh   <= rd_data;
                        bit_cnt <= 5'h00;
                        state   <= ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_rise) begin
                     wr_sh   <= {wr_sh[6:0], sdi_s};
                     bit_cnt <= bit_cnt + 5'h01;
                     if (bit_cnt == `ODCD_BYTE_LAST) begin
                        // Byte done: commit write, step address down
                        wr_stb  <= ~rd_mode;
                        wr_addr <= addr;
                        wr_data <= {wr_sh[6:0], sdi_s};
                        addr    <= next_addr;
                        rd_sh   <= rd_data;
                        bit_cnt <= 5'h00;
                     end
                  end else if (sclk_fall && rd_mode) begin
                     // Read bits change on the falling edge, MSB first
                     sci_sdo_o    <= rd_sh[7];
                     sci_sdo_oe_o <= 1'b1;
                     rd_sh        <= {rd_sh[6:0], 1'b0};
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   // Writes to unmapped addresses are dropped without effect.
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < NUM_OUT; i = i + 1) begin
            div_set[i] <= `ODCD_SET_RESET;
            div_ctl[i] <= `ODCD_CTL_RESET;
         end
      end else if (wr_stb) begin
         if (set_hit(wr_addr)) begin
            div_set[out_idx(wr_addr)] <= wr_data;
         end else if (ctl_hit(wr_addr)) begin
            div_ctl[out_idx(wr_addr)] <= wr_data;
         end
      end
   end

   // ****************************************************************
   // Bypass select to the output mux
   // ****************************************************************
   // The fast clock itself cannot come from a flop, so the output
   // stage switches to it on this flag.
   always @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         bypass_sel_o <= {NUM_OUT{1'b0}};
      end else begin
         for (j = 0; j < NUM_OUT; j = j + 1) begin
            bypass_sel_o[j] <= div_ctl[j][`ODCD_CTL_BYPASS];
         end
      end
   end

   // ****************************************************************
   // Dividers, one per clock output
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_div
         odcd_divider #(
            .CNT_W        (CNT_W)
         ) odcd_divider_inst (
            .clk_i        (clk_sys_i),
            .rstn_i       (rst_n),
            .on_cnt_i     (div_set[g][`ODCD_ON_MSB:`ODCD_ON_LSB]),
            .off_cnt_i    (div_set[g][`ODCD_OFF_MSB:`ODCD_OFF_LSB]),
            .phase_i      (div_ctl[g][`ODCD_PHASE_MSB:`ODCD_PHASE_LSB]),
            .bypass_i     (div_ctl[g][`ODCD_CTL_BYPASS]),
            .start_high_i (div_ctl[g][`ODCD_CTL_START_HI]),
            .no_align_i   (div_ctl[g][`ODCD_CTL_NO_ALIGN]),
            .hold_i       (hold_s),
            .div_o        (clock_outputs_o[g])
         );
      end
   endgenerate

endmodule
